// [hw/ctr_slice.sv]
// counter slice: period, pulse width, divide-down and quadrature position
// How it works
// - arming starts one gate period measurement
// - gate active edge rising or falling
// - count active source edges between gate edges
// - on-demand position read and sample-clocked capture
// - decode rate one, two or four
// - encoder inputs A, B and index Z
// - single rate: A rise, A leads, count up
// - single rate: A fall, B leads, count down
// - known gate pulse from pair gives frequency
// - divide source by N for pair timing
// - pair gate input links fixed counter pair
// - double rate counts every A edge
// - quad rate counts every A and B edge
//
// The implementer's own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ns
module ctr_slice
  import ctr_pkg::*;
(
  input  wire logic          clk_sys_i,
  input  wire logic          nrst_i,
  input  wire logic [AW-1:0] addr_i,
  input  wire logic [DW-1:0] wdata_i,
  input  wire logic          wr_i,
  input  wire logic          rd_i,
  output logic      [DW-1:0] rdata_o,
  input  wire logic          gate_i,
  input  wire logic          source_i,
  input  wire logic          enc_a_i,
  input  wire logic          enc_b_i,
  input  wire logic          enc_z_i,
  input  wire logic          samp_clk_i,
  input  wire logic          pair_gate_i,
  output logic               pair_out_o
);

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers

  edge_t gate_e;
  edge_t pair_e;
  edge_t src_e;
  edge_t a_e;
  edge_t b_e;
  edge_t z_e;
  edge_t samp_e;

  edge_sync u_sync_gate (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .in_i      (gate_i),
    .edge_o    (gate_e)
  );
  edge_sync u_sync_pair (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .in_i      (pair_gate_i),
    .edge_o    (pair_e)
  );
  edge_sync u_sync_src (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .in_i      (source_i),
    .edge_o    (src_e)
  );
  edge_sync u_sync_a (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .in_i      (enc_a_i),
    .edge_o    (a_e)
  );
  edge_sync u_sync_b (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .in_i      (enc_b_i),
    .edge_o    (b_e)
  );
  edge_sync u_sync_z (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .in_i      (enc_z_i),
    .edge_o    (z_e)
  );
  edge_sync u_sync_samp (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .in_i      (samp_clk_i),
    .edge_o    (samp_e)
  );

  ////////////////////////////////////////////////////////////////////////////
  // register file and edge selection

  ctrl_t         ctrl_q, ctrl_d;
  logic [DW-1:0] divide_q, divide_d;
  logic          wr_ctrl, arm_cmd, disarm_cmd;
  edge_t         g_e;
  logic          g_act, g_inact, s_act;
  logic          step_up, step_down;

  always_comb begin
    wr_ctrl    = wr_i & (addr_i == REG_CTRL);
    arm_cmd    = wr_i & (addr_i == REG_CMD) & wdata_i[CMD_ARM_BIT];
    disarm_cmd = wr_i & (addr_i == REG_CMD) & wdata_i[CMD_DISARM_BIT];
    ctrl_d     = ctrl_q;
    divide_d   = divide_q;
    if (wr_ctrl) begin
      ctrl_d      = ctrl_t'(wdata_i);
      ctrl_d.rsvd = '0;
    end
    if (wr_i && addr_i == REG_DIVIDE) begin
      divide_d = wdata_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl_q   <= ctrl_t'(CTRL_RST);
      divide_q <= DIVIDE_RST;
    end else begin
      ctrl_q   <= ctrl_d;
      divide_q <= divide_d;
    end
  end

  always_comb begin
    g_e     = ctrl_q.gate_from_pair ? pair_e : gate_e;
    g_act   = ctrl_q.gate_fall ? g_e.fall : g_e.rise;
    g_inact = ctrl_q.gate_fall ? g_e.rise : g_e.fall;
    s_act   = ctrl_q.src_fall ? src_e.fall : src_e.rise;
  end

  quad_decode u_quad (
    .rate_i (ctrl_q.decode),
    .a_i    (a_e),
    .b_i    (b_e),
    .up_o   (step_up),
    .down_o (step_down)
  );

  ////////////////////////////////////////////////////////////////////////////
  // measurement state machine

  state_t        state_q, state_d;
  logic [DW-1:0] cnt_q, cnt_d;
  logic [DW-1:0] result_q, result_d;
  logic [DW-1:0] pos_q, pos_d;
  logic [DW-1:0] sample_q, sample_d;
  logic [DW-1:0] samp_cnt_q, samp_cnt_d;
  logic          done_q, done_d;
  logic          ovf_q, ovf_d;
  logic          out_q, out_d;
  logic          stop_edge;

  always_comb begin
    state_d    = state_q;
    cnt_d      = cnt_q;
    result_d   = result_q;
    pos_d      = pos_q;
    sample_d   = sample_q;
    samp_cnt_d = samp_cnt_q;
    done_d     = done_q;
    ovf_d      = ovf_q;
    out_d      = out_q;
    stop_edge  = (ctrl_q.mode == MODE_PULSE) ? g_inact : g_act;
    unique case (state_q)
      ST_IDLE: begin
        if (arm_cmd) begin
          done_d = 1'b0;
          ovf_d  = 1'b0;
          cnt_d  = COUNT_RST;
          unique case (ctrl_q.mode)
            MODE_POSITION: begin
              pos_d      = COUNT_RST;
              samp_cnt_d = COUNT_RST;
              state_d    = ST_TRACK;
            end
            MODE_DIVIDE: begin
              out_d   = 1'b1;
              state_d = ST_COUNT;
            end
            default: state_d = ST_WAIT;
          endcase
        end
      end
      ST_WAIT: begin
        if (disarm_cmd) begin
          state_d = ST_IDLE;
        end else if (g_act) begin
          cnt_d   = COUNT_RST;
          state_d = ST_COUNT;
        end
      end
      ST_COUNT: begin
        if (disarm_cmd) begin
          out_d   = 1'b0;
          state_d = ST_IDLE;
        end else if (ctrl_q.mode == MODE_DIVIDE) begin
          if (s_act) begin
            // pulse stays high for N active source edges
            if (cnt_q + 32'h1 >= divide_q) begin
              out_d    = 1'b0;
              result_d = cnt_q + 32'h1;
              done_d   = 1'b1;
              state_d  = ST_IDLE;
            end else begin
              cnt_d = cnt_q + 32'h1;
            end
          end
        end else if (stop_edge) begin
          result_d = cnt_q;
          done_d   = 1'b1;
          state_d  = ST_IDLE;
        end else if (s_act) begin
          cnt_d = cnt_q + 32'h1;
          if (cnt_q == '1) begin
            ovf_d = 1'b1;
          end
        end
      end
      ST_TRACK: begin
        if (disarm_cmd) begin
          state_d = ST_IDLE;
        end else begin
          if (step_up) begin
            pos_d = pos_q + 32'h1;
          end else if (step_down) begin
            pos_d = pos_q - 32'h1;
          end
          if (ctrl_q.buffered && samp_e.rise) begin
            sample_d   = pos_q;
            samp_cnt_d = samp_cnt_q + 32'h1;
          end
        end
      end
      default: begin
        out_d   = 1'b0;
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q    <= ST_IDLE;
      cnt_q      <= COUNT_RST;
      result_q   <= COUNT_RST;
      pos_q      <= COUNT_RST;
      sample_q   <= COUNT_RST;
      samp_cnt_q <= COUNT_RST;
      done_q     <= 1'b0;
      ovf_q      <= 1'b0;
      out_q      <= 1'b0;
    end else begin
      state_q    <= state_d;
      cnt_q      <= cnt_d;
      result_q   <= result_d;
      pos_q      <= pos_d;
      sample_q   <= sample_d;
      samp_cnt_q <= samp_cnt_d;
      done_q     <= done_d;
      ovf_q      <= ovf_d;
      out_q      <= out_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read port, data one cycle after the strobe

  logic [DW-1:0] rdata_q, rdata_d;
  logic [DW-1:0] status;

  always_comb begin
    status                 = '0;
    status[STAT_ARMED_BIT] = (state_q != ST_IDLE);
    status[STAT_DONE_BIT]  = done_q;
    status[STAT_OVF_BIT]   = ovf_q;
    status[STAT_INDEX_BIT] = z_e.lvl;
    rdata_d                = '0;
    if (rd_i) begin
      unique case (addr_i)
        REG_CTRL:       rdata_d = ctrl_q;
        REG_STATUS:     rdata_d = status;
        REG_RESULT:     rdata_d = result_q;
        REG_POSITION:   rdata_d = pos_q;
        REG_SAMPLE:     rdata_d = sample_q;
        REG_DIVIDE:     rdata_d = divide_q;
        REG_SAMPLE_CNT: rdata_d = samp_cnt_q;
        default:        rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  always_comb begin
    rdata_o    = rdata_q;
    pair_out_o = out_q;
  end

endmodule

// [hw/ctr_pkg.sv]
// shared constants, register map and types for the period/quadrature counter
package ctr_pkg;

  localparam int unsigned DW = 32;
  localparam int unsigned AW = 8;

  // register byte offsets
  localparam logic [AW-1:0] REG_CTRL       = 8'h00;
  localparam logic [AW-1:0] REG_CMD        = 8'h04;
  localparam logic [AW-1:0] REG_STATUS     = 8'h08;
  localparam logic [AW-1:0] REG_RESULT     = 8'h0c;
  localparam logic [AW-1:0] REG_POSITION   = 8'h10;
  localparam logic [AW-1:0] REG_SAMPLE     = 8'h14;
  localparam logic [AW-1:0] REG_DIVIDE     = 8'h18;
  localparam logic [AW-1:0] REG_SAMPLE_CNT = 8'h1c;

  // command bits (write-one actions)
  localparam int unsigned CMD_ARM_BIT    = 0;
  localparam int unsigned CMD_DISARM_BIT = 1;

  // status bits
  localparam int unsigned STAT_ARMED_BIT = 0;
  localparam int unsigned STAT_DONE_BIT  = 1;
  localparam int unsigned STAT_OVF_BIT   = 2;
  localparam int unsigned STAT_INDEX_BIT = 3;

  // reset values
  localparam logic [DW-1:0] CTRL_RST   = 32'h0000_0000;
  localparam logic [DW-1:0] DIVIDE_RST = 32'h0000_0002;
  localparam logic [DW-1:0] COUNT_RST  = 32'h0000_0000;

  typedef enum logic [1:0] {
    MODE_PERIOD   = 2'h0,
    MODE_PULSE    = 2'h1,
    MODE_POSITION = 2'h2,
    MODE_DIVIDE   = 2'h3
  } mode_t;

  typedef enum logic [1:0] {
    SINGLE_RATE_DECODE = 2'h0,
    DOUBLE_RATE_DECODE = 2'h1,
    QUAD_RATE_DECODE   = 2'h2
  } decode_t;

  // control register layout, lsb last
  typedef struct packed {
    logic [23:0] rsvd;
    logic        gate_from_pair;
    logic        buffered;
    decode_t     decode;
    logic        src_fall;
    logic        gate_fall;
    mode_t       mode;
  } ctrl_t;

  // synchronised input level with its edges
  typedef struct packed {
    logic lvl;
    logic rise;
    logic fall;
  } edge_t;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_WAIT  = 4'b0010,
    ST_COUNT = 4'b0100,
    ST_TRACK = 4'b1000
  } state_t;

endpackage

// [hw/edge_sync.sv]
// two-flop synchroniser with edge detection on the synchronised level
`timescale 1ns/1ns
module edge_sync
  import ctr_pkg::*;
(
  input  wire logic clk_sys_i,
  input  wire logic nrst_i,
  input  wire logic in_i,
  output edge_t     edge_o
);

  logic meta_q, meta_d;
  logic sync_q, sync_d;
  logic prev_q, prev_d;

  // meta_q feeds only sync_q
  always_comb begin
    meta_d = in_i;
    sync_d = meta_q;
    prev_d = sync_q;
  end

  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      prev_q <= prev_d;
    end
  end

  always_comb begin
    edge_o.lvl  = sync_q;
    edge_o.rise = sync_q & ~prev_q;
    edge_o.fall = ~sync_q & prev_q;
  end

endmodule

// [hw/quad_decode.sv]
// quadrature step decoder: one-cycle up/down steps at 1x, 2x or 4x rate
`timescale 1ns/1ns
module quad_decode
  import ctr_pkg::*;
(
  input  decode_t    rate_i,
  input  edge_t      a_i,
  input  edge_t      b_i,
  output logic       up_o,
  output logic       down_o
);

  always_comb begin
    up_o   = 1'b0;
    down_o = 1'b0;
    unique case (rate_i)
      SINGLE_RATE_DECODE: begin
        up_o   = a_i.rise & ~b_i.lvl;
        down_o = a_i.fall & ~b_i.lvl;
      end
      DOUBLE_RATE_DECODE: begin
        up_o   = (a_i.rise & ~b_i.lvl) | (a_i.fall & b_i.lvl);
        down_o = (a_i.rise & b_i.lvl) | (a_i.fall & ~b_i.lvl);
      end
      QUAD_RATE_DECODE: begin
        up_o   = (a_i.rise & ~b_i.lvl) | (a_i.fall & b_i.lvl)
               | (b_i.rise & a_i.lvl) | (b_i.fall & ~a_i.lvl);
        down_o = (a_i.rise & b_i.lvl) | (a_i.fall & ~b_i.lvl)
               | (b_i.rise & ~a_i.lvl) | (b_i.fall & a_i.lvl);
      end
      default: begin
        up_o   = 1'b0;
        down_o = 1'b0;
      end
    endcase
  end

endmodule

// [dv/ctr_slice_assertions.sv]
// concurrent checks on the counter slice register port and pair output
`timescale 1ns/1ns
module ctr_slice_checker
  import ctr_pkg::*;
(
  input wire logic          clk_sys_i,
  input wire logic          nrst_i,
  input wire logic [AW-1:0] addr_i,
  input wire logic [DW-1:0] wdata_i,
  input wire logic          wr_i,
  input wire logic          rd_i,
  input wire logic [DW-1:0] rdata_o,
  input wire logic          enc_z_i,
  input wire logic          pair_out_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);
  logic arm_w;
  assign arm_w = wr_i && addr_i == REG_CMD && wdata_i[CMD_ARM_BIT];
  sequence ctrl_wr_rd;
    wr_i && addr_i == REG_CTRL ##1 rd_i && addr_i == REG_CTRL;
  endsequence
  sequence div_wr_rd;
    wr_i && addr_i == REG_DIVIDE ##1 rd_i && addr_i == REG_DIVIDE;
  endsequence
  sequence z_steady;
    $stable(enc_z_i) [*4];
  endsequence
  rdata_idle_a: assert property (!rd_i |=> rdata_o == '0)
    else $error("read data not zero outside a read");
  ctrl_readback_a: assert property (
    ctrl_wr_rd |=> rdata_o == {24'h0, $past(wdata_i[7:0], 2)})
    else $error("control readback differs from write");
  divide_readback_a: assert property (
    div_wr_rd |=> rdata_o == $past(wdata_i, 2))
    else $error("divide readback differs from write");
  cmd_reads_zero_a: assert property (rd_i && addr_i == REG_CMD |=> rdata_o == '0)
    else $error("command register not read as zero");
  unmapped_zero_a: assert property (
    rd_i && addr_i > REG_SAMPLE_CNT |=> rdata_o == '0)
    else $error("unmapped read not zero");
  status_upper_a: assert property (
    rd_i && addr_i == REG_STATUS |=> rdata_o[DW-1:4] == '0)
    else $error("status upper bits not zero");
  index_level_a: assert property (
    z_steady ##0 rd_i && addr_i == REG_STATUS |=> rdata_o[STAT_INDEX_BIT] == $past(enc_z_i))
    else $error("index level wrong in status");
  pair_out_rise_a: assert property (
    $rose(pair_out_o) |-> $past(arm_w) || $past(arm_w, 2))
    else $error("pair output rose without arming");
endmodule

bind ctr_slice ctr_slice_checker i_ctr_slice_checker (.clk_sys_i, .nrst_i, .addr_i,
  .wdata_i, .wr_i, .rd_i, .rdata_o, .enc_z_i, .pair_out_o);

// [dv/enc_src_model.sv]
// far side: quadrature encoder, gate signal and free-running source timebase
`timescale 1ns/1ns
module enc_src_model (
  input  wire logic clk_sys_i,
  output logic      enc_a_o,
  output logic      enc_b_o,
  output logic      gate_o,
  output logic      source_o
);
  logic [1:0] ph;
  logic       odd;
  initial begin
    {enc_a_o, enc_b_o, gate_o, source_o, odd} = '0;
    ph = 2'h0;
  end
  // source moves on odd cycles, gate_toggle moves gate only on even ones, so those edges never coincide
  always @(posedge clk_sys_i) begin
    odd <= ~odd;
    if (odd)
      source_o <= ~source_o;
  end
  task automatic gate_set(input logic l);
    @(posedge clk_sys_i);
    gate_o <= l;
  endtask
  // known-width gate pulses for the measuring counter
  task automatic gate_toggle(input int hold);
    repeat (hold) @(posedge clk_sys_i);
    while (odd)
      @(posedge clk_sys_i);
    gate_o <= ~gate_o;
  endtask
  task automatic quad(input int n, input logic fwd, input int hold);
    for (int i = 0; i < n; i++) begin
      repeat (hold) @(posedge clk_sys_i);
      ph = fwd ? ph + 2'h1 : ph - 2'h1;
      enc_a_o <= ph[1] ^ ph[0];
      enc_b_o <= ph[1];
    end
  endtask
endmodule

// [dv/counter_period_quadrature_tb.sv]
// self-checking bench for the period/quadrature counter slice
`timescale 1ns/1ns
module counter_period_quadrature_tb;
  import ctr_pkg::*;
  logic          clk_sys_i = 1'b0;
  logic          nrst_i = 1'b0;
  logic [AW-1:0] addr_i = '0;
  logic [DW-1:0] wdata_i = '0;
  logic          wr_i = 1'b0, rd_i = 1'b0, enc_z_i = 1'b0, samp_clk_i = 1'b0;
  logic          use_pair = 1'b0, noise = 1'b0, sf = 1'b0, track = 1'b0, po_seen = 1'b0;
  logic          pa = 1'b0, pb = 1'b0, pg = 1'b0, ps = 1'b0;
  logic [DW-1:0] rdata_o, v;
  logic          enc_a, enc_b, mgate, source, pair_out_o;
  decode_t       rate;
  ctrl_t         c;
  int            num_errors = 0, compares = 0, seed = 95, src_cnt = 0, exp_pos = 0, n, es;
  int            gsnap[$];

  ctr_slice i_ctr_slice (.clk_sys_i, .nrst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .gate_i(use_pair ? noise : mgate), .source_i(source), .enc_a_i(enc_a), .enc_b_i(enc_b),
    .enc_z_i, .samp_clk_i, .pair_gate_i(use_pair ? mgate : noise), .pair_out_o);
  enc_src_model i_enc_src_model (.clk_sys_i, .enc_a_o(enc_a), .enc_b_o(enc_b),
    .gate_o(mgate), .source_o(source));

  always #10 clk_sys_i = ~clk_sys_i;
  always begin
    repeat (7) @(posedge clk_sys_i);
    noise <= ~noise;
  end
  ////////////////////////////////////////////////////////////////////////////////
  function automatic int delta(input logic a, input logic b, input logic qa, input logic qb);
    int d;
    d = 0;
    if (a != qa && (rate != SINGLE_RATE_DECODE || !b))
      d = (a ^ b) ? 1 : -1;
    if (b != qb && rate == QUAD_RATE_DECODE)
      d = (a ^ b) ? -1 : 1;
    return d;
  endfunction
  // reference counts taken from the pins
  always @(posedge clk_sys_i) begin
    if (source !== ps && source === ~sf)
      src_cnt++;
    if (mgate !== pg)
      gsnap.push_back(src_cnt);
    if (track)
      exp_pos += delta(enc_a, enc_b, pa, pb);
    if (pair_out_o === 1'b1)
      po_seen = 1'b1;
    pa <= enc_a;
    pb <= enc_b;
    pg <= mgate;
    ps <= source;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge clk_sys_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
  endtask
  // write then read back the same register with no gap between the strobes
  task automatic wr_rd(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge clk_sys_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    @(negedge clk_sys_i);
    v = rdata_o;
  endtask
  task automatic rd(input logic [AW-1:0] a);
    @(posedge clk_sys_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    @(negedge clk_sys_i);
    v = rdata_o;
  endtask
  task automatic wait_done;
    for (int i = 0; i < 300; i++) begin
      rd(REG_STATUS);
      if (v[STAT_DONE_BIT] === 1'b1)
        return;
    end
    num_errors++;
  endtask
  task automatic meas(input mode_t m, input logic gf, input logic s);
    c = '0;
    c.mode = m;
    c.gate_fall = gf;
    c.src_fall = s;
    c.gate_from_pair = use_pair;
    sf <= s;
    wr_rd(REG_CTRL, c);
    chk(v, c);
    i_enc_src_model.gate_set(gf);
    repeat (6) @(posedge clk_sys_i);
    wr(REG_CMD, 32'h1);
    gsnap.delete();
    repeat (3) i_enc_src_model.gate_toggle(4 + 2 * ({$random(seed)} % 4));
    wait_done;
    rd(REG_RESULT);
    chk(v, gsnap[m == MODE_PERIOD ? 2 : 1] - gsnap[0]);
  endtask
  task automatic results;
    if (num_errors == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (50000) @(posedge clk_sys_i);
    num_errors++;
    results;
  end
  initial begin
    repeat (5) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    rd(REG_CTRL);
    chk(v, CTRL_RST);
    rd(REG_DIVIDE);
    chk(v, DIVIDE_RST);
    wr(8'h24, 32'hffff_ffff);
    rd(8'h24);
    chk(v, '0);
    rd(REG_CMD);
    chk(v, '0);
    for (int i = 0; i < 4; i++)
      meas(MODE_PERIOD, i[0], i[1]);
    @(posedge clk_sys_i);
    use_pair <= 1'b1;
    @(posedge clk_sys_i);
    meas(MODE_PULSE, 1'b0, 1'b0);
    @(posedge clk_sys_i);
    use_pair <= 1'b0;
    n = 1 + {$random(seed)} % 4;
    c = '0;
    c.mode = MODE_DIVIDE;
    wr_rd(REG_DIVIDE, n);
    chk(v, n);
    wr(REG_CTRL, c);
    po_seen = 1'b0;
    wr(REG_CMD, 32'h1);
    wait_done;
    rd(REG_RESULT);
    chk(v, n);
    chk({31'h0, po_seen & ~pair_out_o}, 32'h1);
    for (int r = 0; r < 3; r++) begin
      rate = decode_t'(r);
      c = '0;
      c.mode = MODE_POSITION;
      c.decode = rate;
      c.buffered = 1'b1;
      wr(REG_CTRL, c);
      i_enc_src_model.quad(3, 1'b1, 3);
      repeat (6) @(posedge clk_sys_i);
      wr(REG_CMD, 32'h1);
      exp_pos = 0;
      track = 1'b1;
      i_enc_src_model.quad(4 + {$random(seed)} % 8, 1'b1, 2 + {$random(seed)} % 3);
      repeat (6) @(posedge clk_sys_i);
      es = exp_pos;
      samp_clk_i <= 1'b1;
      repeat (3) @(posedge clk_sys_i);
      samp_clk_i <= 1'b0;
      i_enc_src_model.quad(2 + {$random(seed)} % 12, 1'b0, 2);
      repeat (6) @(posedge clk_sys_i);
      rd(REG_POSITION);
      chk(v, exp_pos);
      rd(REG_SAMPLE);
      chk(v, es);
      rd(REG_SAMPLE_CNT);
      chk(v, 32'h1);
      wr(REG_CMD, 32'h2);
      track = 1'b0;
      i_enc_src_model.quad(3, 1'b1, 2);
      repeat (6) @(posedge clk_sys_i);
      rd(REG_POSITION);
      chk(v, exp_pos);
    end
    @(posedge clk_sys_i);
    enc_z_i <= 1'b1;
    repeat (6) @(posedge clk_sys_i);
    rd(REG_STATUS);
    chk(v & 32'h8, 32'h8);
    results;
  end
endmodule
